// ==== verilog/dpgdt_defs.vh ====
// Constants for the dual pulse generator with dead time
`ifndef DPGDT_DEFS_VH
`define DPGDT_DEFS_VH

// Data register select codes on the write and read ports
`define DPGDT_SEL_DEAD1   3'h0
`define DPGDT_SEL_WIDTH1  3'h1
`define DPGDT_SEL_PERIOD  3'h2
`define DPGDT_SEL_DEAD2   3'h3
`define DPGDT_SEL_WIDTH2  3'h4

// Waveform mode field encodings
`define DPGDT_MODE_HALF   2'h3
`define DPGDT_MODE_VAR    2'h2
`define DPGDT_MODE_INDEP  2'h0

// Data register width and reset value
`define DPGDT_DW          10
`define DPGDT_DATA_RST    10'h000

// Upper byte field of a data register
`define DPGDT_HI_MSB      1
`define DPGDT_HI_LSB      0

`endif

// ==== verilog/dpgdt_window.v ====
// Window comparator: active while low bound <= count < high bound
`timescale 1ns/10ps
module dpgdt_window #(
   parameter CW = 10
) (
   input  wire [CW-1:0] count,
   input  wire [CW:0]   lo_bound,
   input  wire [CW:0]   hi_bound,
   output wire          active
);

   // Dead time delays the start, pulse width end point ends it
   assign active = ({1'b0, count} >= lo_bound) && ({1'b0, count} < hi_bound);
endmodule

// ==== verilog/dpgdt_core.v ====
// Dual pulse generator with dead time: holding, compare, counter and outputs
//
// Operation
// - Each data value has a holding register and a separate compare register.
// - Transfers copy only holding values that the selected mode uses.
// - Period upper byte write arms a transfer done at counter match or counter start.
// - Values at arming apply next period; later writes apply the period after.
// - Both outputs come from comparing a 10-bit up counter with compare values.
// - Mode 11 is half duty, 10 variable complementary, 00 independent.
// - Half mode: output one first half, output two second half.
// - Half mode odd period: output two active one count longer.
// - Nonzero dead time shortens each affected active duration by its count.
// - Variable mode: output one for width, output two for the rest.
// - Period 400H is accepted and reads back as 000H.
// - Independent mode: common period, own dead time and width per output.
// - Independent mode dead time at or above period gives zero duty.
// - Counter clears at period; continues or stops per repeat selection.
`timescale 1ns/10ps
`include "dpgdt_defs.vh"
module dpgdt_core #(
   parameter DW = `DPGDT_DW
) (
   input  wire          sys_clk,
   input  wire          rst,
   input  wire [1:0]    waveform_mode_select,
   input  wire          repeat_select,
   input  wire          run_control,
   input  wire          data_wr_stb,
   input  wire [2:0]    data_wr_sel,
   input  wire          data_wr_hi,
   input  wire [7:0]    data_wr_byte,
   input  wire [2:0]    data_rd_sel,
   input  wire          data_rd_hi,
   output reg  [7:0]    data_rd_byte,
   output reg           pulse_output_one,
   output reg           pulse_output_two,
   output reg           counting_flag,
   output reg           transfer_pending
);

   // Extend a stored value: zero stands for the full range 400H
   function [DW:0] full_ext;
      input [DW-1:0] v;
      begin
         full_ext = {(v == {DW{1'b0}}), v};
      end
   endfunction

   // Zero extend a value to comparison width
   function [DW:0] zext;
      input [DW-1:0] v;
      begin
         zext = {1'b0, v};
      end
   endfunction

   reg  [DW-1:0] hold_reg [0:4];
   reg  [DW-1:0] stage_reg [0:4];
   reg  [DW-1:0] cmp_reg [0:4];
   reg  [DW-1:0] cnt_reg;
   reg           run_d_reg;
   reg           dirty_reg;
   reg  [DW:0]   lo1;
   reg  [DW:0]   hi1;
   reg  [DW:0]   lo2;
   reg  [DW:0]   hi2;
   reg  [DW:0]   half_pt;
   reg  [4:0]    use_mask;
   wire [DW:0]   period_ext;
   wire          start_evt;
   wire          match_evt;
   wire          xfer_evt;
   wire          arm_evt;
   wire          act1;
   wire          act2;
   integer       i;

   assign period_ext = full_ext(cmp_reg[`DPGDT_SEL_PERIOD]);
   assign start_evt  = run_control & ~run_d_reg;
   assign match_evt  = counting_flag && (zext(cnt_reg) == period_ext - 11'h001);
   assign xfer_evt   = transfer_pending && (match_evt || start_evt);
   assign arm_evt    = data_wr_stb && data_wr_hi && (data_wr_sel == `DPGDT_SEL_PERIOD);

   // Holding registers used by each mode
   always @* begin
      case (waveform_mode_select)
         `DPGDT_MODE_HALF:  use_mask = 5'h05;
         `DPGDT_MODE_VAR:   use_mask = 5'h07;
         `DPGDT_MODE_INDEP: use_mask = 5'h1F;
         default:           use_mask = 5'h04;
      endcase
   end

   // Software writes into holding registers, low byte then high byte
   always @(posedge sys_clk) begin
      if (rst) begin
         for (i = 0; i < 5; i = i + 1) begin
            hold_reg[i] <= `DPGDT_DATA_RST;
         end
      end else if (data_wr_stb && (data_wr_sel <= `DPGDT_SEL_WIDTH2)) begin
         if (data_wr_hi) begin
            // Only two bits kept, so 400H reads back as 000H
            hold_reg[data_wr_sel][DW-1:8] <= data_wr_byte[`DPGDT_HI_MSB:`DPGDT_HI_LSB];
         end else begin
            hold_reg[data_wr_sel][7:0] <= data_wr_byte;
         end
      end
   end

   // Staging snapshot, pending request and compare registers
   always @(posedge sys_clk) begin
      if (rst) begin
         for (i = 0; i < 5; i = i + 1) begin
            stage_reg[i] <= `DPGDT_DATA_RST;
            cmp_reg[i]   <= `DPGDT_DATA_RST;
         end
         transfer_pending <= 1'b0;
         dirty_reg        <= 1'b0;
      end else begin
         if (xfer_evt) begin
            for (i = 0; i < 5; i = i + 1) begin
               if (use_mask[i]) begin
                  cmp_reg[i] <= stage_reg[i];
               end
            end
         end
         if (arm_evt) begin
            // Snapshot at arming, including the period byte being written
            for (i = 0; i < 5; i = i + 1) begin
               stage_reg[i] <= hold_reg[i];
            end
            stage_reg[`DPGDT_SEL_PERIOD][DW-1:8] <=
               data_wr_byte[`DPGDT_HI_MSB:`DPGDT_HI_LSB];
            transfer_pending <= 1'b1;
            dirty_reg        <= 1'b0;
         end else if (xfer_evt) begin
            // Writes after arming are carried to the following period
            if (dirty_reg) begin
               for (i = 0; i < 5; i = i + 1) begin
                  stage_reg[i] <= hold_reg[i];
               end
            end
            // A write in the transfer cycle still counts as a late write
            transfer_pending <= dirty_reg | data_wr_stb;
            dirty_reg        <= data_wr_stb;
         end else if (data_wr_stb && transfer_pending) begin
            dirty_reg <= 1'b1;
         end
      end
   end

   // Up counter with start, period clear and repeat selection
   always @(posedge sys_clk) begin
      if (rst) begin
         cnt_reg       <= {DW{1'b0}};
         counting_flag <= 1'b0;
         run_d_reg     <= 1'b0;
      end else begin
         run_d_reg <= run_control;
         if (!run_control) begin
            counting_flag <= 1'b0;
            cnt_reg       <= {DW{1'b0}};
         end else if (start_evt) begin
            counting_flag <= 1'b1;
            cnt_reg       <= {DW{1'b0}};
         end else if (match_evt) begin
            cnt_reg <= {DW{1'b0}};
            if (repeat_select) begin
               counting_flag <= 1'b0;
            end
         end else if (counting_flag) begin
            cnt_reg <= cnt_reg + {{(DW-1){1'b0}}, 1'b1};
         end
      end
   end

   // Active windows for each output by waveform mode
   always @* begin
      half_pt = {1'b0, period_ext[DW:1]};
      lo1 = zext(cmp_reg[`DPGDT_SEL_DEAD1]);
      hi1 = {(DW+1){1'b0}};
      lo2 = {(DW+1){1'b0}};
      hi2 = {(DW+1){1'b0}};
      case (waveform_mode_select)
         `DPGDT_MODE_HALF: begin
            hi1 = half_pt;
            lo2 = half_pt + zext(cmp_reg[`DPGDT_SEL_DEAD1]);
            hi2 = period_ext;
         end
         `DPGDT_MODE_VAR: begin
            hi1 = full_ext(cmp_reg[`DPGDT_SEL_WIDTH1]);
            lo2 = zext(cmp_reg[`DPGDT_SEL_WIDTH1]) + zext(cmp_reg[`DPGDT_SEL_DEAD1]);
            hi2 = period_ext;
         end
         `DPGDT_MODE_INDEP: begin
            hi1 = full_ext(cmp_reg[`DPGDT_SEL_WIDTH1]);
            lo2 = zext(cmp_reg[`DPGDT_SEL_DEAD2]);
            hi2 = full_ext(cmp_reg[`DPGDT_SEL_WIDTH2]);
         end
         default: begin
            lo1 = {(DW+1){1'b0}};
         end
      endcase
   end

   dpgdt_window #(
      .CW       (DW)
   ) u_win_one (
      .count    (cnt_reg),
      .lo_bound (lo1),
      .hi_bound (hi1),
      .active   (act1)
   );

   dpgdt_window #(
      .CW       (DW)
   ) u_win_two (
      .count    (cnt_reg),
      .lo_bound (lo2),
      .hi_bound (hi2),
      .active   (act2)
   );

   // Registered pins; counter never reaches period, so dead >= period stays off
   // Run control low drops both pins at the same edge that stops the counter
   always @(posedge sys_clk) begin
      if (rst) begin
         pulse_output_one <= 1'b0;
         pulse_output_two <= 1'b0;
      end else begin
         pulse_output_one <= run_control & counting_flag & act1 & (lo1 < period_ext);
         pulse_output_two <= run_control & counting_flag & act2 & (lo2 < period_ext);
      end
   end

   // Registered read back of holding registers, unused bits zero
   always @(posedge sys_clk) begin
      if (rst) begin
         data_rd_byte <= 8'h00;
      end else if (data_rd_sel > `DPGDT_SEL_WIDTH2) begin
         data_rd_byte <= 8'h00;
      end else if (data_rd_hi) begin
         data_rd_byte <= {6'h00, hold_reg[data_rd_sel][DW-1:8]};
      end else begin
         data_rd_byte <= hold_reg[data_rd_sel][7:0];
      end
   end
endmodule

// ==== testbench/dpgdt_core_sva.sv ====
// Checker for the dual pulse generator ports
`timescale 1ns/10ps
module dpgdt_core_sva (
   input wire       sys_clk,
   input wire       rst,
   input wire [1:0] waveform_mode_select,
   input wire       repeat_select,
   input wire       run_control,
   input wire       data_wr_stb,
   input wire [2:0] data_wr_sel,
   input wire       data_wr_hi,
   input wire       data_rd_hi,
   input wire [7:0] data_rd_byte,
   input wire       pulse_output_one,
   input wire       pulse_output_two,
   input wire       counting_flag,
   input wire       transfer_pending
);
   reg [10:0] run_len_reg;
   // Length of the current counting run
   always @(posedge sys_clk)
      run_len_reg <= (rst || !counting_flag) ? 11'h000 : run_len_reg + 11'h001;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   AST_STOP: assert property (!run_control |=> !counting_flag && !pulse_output_one
      && !pulse_output_two) else $error("stop left activity");
   AST_START: assert property ($rose(run_control) |=> counting_flag)
      else $error("no start");
   AST_EXCL: assert property (waveform_mode_select[1] |->
      !(pulse_output_one && pulse_output_two)) else $error("outputs overlap");
   AST_ARM: assert property (data_wr_stb && data_wr_sel == 3'h2 && data_wr_hi
      |=> transfer_pending) else $error("not armed");
   AST_HOLD: assert property (transfer_pending && !run_control |=> transfer_pending)
      else $error("request lost");
   AST_RDHI: assert property (data_rd_hi |=> data_rd_byte[7:2] == 6'h00)
      else $error("upper bits set");
   AST_ONE: assert property (repeat_select |-> run_len_reg <= 11'h400)
      else $error("one-time run too long");
   AST_FELL: assert property ($fell(counting_flag) |=> !pulse_output_one
      && !pulse_output_two) else $error("output after stop");
   cover property ($rose(run_control));
   cover property (pulse_output_one && pulse_output_two);
   cover property ($fell(transfer_pending));
endmodule

// ==== testbench/dpgdt_core_tb.sv ====
// Self-checking bench for the dual pulse generator
`timescale 1ns/10ps
module dpgdt_core_tb;
   reg         sys_clk = 1'b0;
   reg         rst = 1'b1;
   reg  [1:0]  mode = 2'h0;
   reg         rep = 1'b0;
   reg         run = 1'b0;
   reg         stb = 1'b0;
   reg  [2:0]  sel = 3'h0;
   reg         hi = 1'b0;
   reg  [7:0]  wb = 8'h00;
   reg  [2:0]  rsel = 3'h0;
   reg         rhi = 1'b0;
   wire [7:0]  rdb;
   wire        o1, o2, cf, tp;
   integer     fail_count = 0;
   integer     comparisons = 0;
   integer     i, k;
   reg  [73:0] rows [0:4];
   reg  [73:0] r;
   reg  [10:0] n1, n2;
   dpgdt_core u_dut (.sys_clk(sys_clk), .rst(rst), .waveform_mode_select(mode),
      .repeat_select(rep), .run_control(run), .data_wr_stb(stb), .data_wr_sel(sel),
      .data_wr_hi(hi), .data_wr_byte(wb), .data_rd_sel(rsel), .data_rd_hi(rhi),
      .data_rd_byte(rdb), .pulse_output_one(o1), .pulse_output_two(o2),
      .counting_flag(cf), .transfer_pending(tp));
   // Clock at 10 MHz
   always #50 sys_clk = ~sys_clk;
   task chk(input [10:0] e, input [10:0] g, input [159:0] nm);
      begin
         comparisons = comparisons + 1;
         if (g !== e) begin
            fail_count = fail_count + 1;
            $display("mismatch %0s expected %0h seen %0h", nm, e, g);
         end
      end
   endtask
   task summarize;
      begin
         $display("comparisons %0d mismatches %0d", comparisons, fail_count);
         if (fail_count == 0 && comparisons > 0) $display("Simulation passed");
         else $display("Simulation failed");
         $finish;
      end
   endtask
   // Write one value, low byte then upper byte
   task wr(input [2:0] s, input [10:0] v);
      begin
         @(posedge sys_clk) #1 stb = 1'b1;
         sel = s;
         hi = 1'b0;
         wb = v[7:0];
         @(posedge sys_clk) #1 hi = 1'b1;
         wb = {5'h00, v[10:8]};
         @(posedge sys_clk) #1 stb = 1'b0;
      end
   endtask
   // Count active cycles of both outputs over one period
   task meas(input [10:0] p, output [10:0] a, output [10:0] b);
      integer j;
      begin
         a = 11'h000;
         b = 11'h000;
         for (j = 0; j < p; j = j + 1) begin
            @(posedge sys_clk) #1 a = a + o1;
            b = b + o2;
         end
      end
   endtask
   // Read a holding register byte
   task rd(input [2:0] s, input h, input [7:0] e);
      begin
         rsel = s;
         rhi = h;
         repeat (2) @(posedge sys_clk);
         #1 chk(11'(e), 11'(rdb), "read");
      end
   endtask
   initial begin
      // Mode, dead1, width1, period, dead2, width2, counts of out one and two
      rows[0] = {2'h3, 10'h002, 10'h000, 10'h00A, 10'h000, 10'h000, 11'h003, 11'h003};
      rows[1] = {2'h3, 10'h000, 10'h000, 10'h00B, 10'h000, 10'h000, 11'h005, 11'h006};
      rows[2] = {2'h2, 10'h001, 10'h006, 10'h014, 10'h000, 10'h000, 11'h005, 11'h00D};
      rows[3] = {2'h0, 10'h002, 10'h005, 10'h010, 10'h000, 10'h010, 11'h003, 11'h010};
      rows[4] = {2'h0, 10'h014, 10'h005, 10'h010, 10'h003, 10'h008, 11'h000, 11'h005};
      repeat (8) @(posedge sys_clk);
      #1 rst = 1'b0;
      chk(11'h000, 11'({cf, tp, o1, o2}), "reset");
      for (i = 0; i < 5; i = i + 1) begin
         r = rows[i];
         repeat (2) @(posedge sys_clk);
         #1 mode = r[73:72];
         wr(3'h0, r[71:62]);
         wr(3'h1, r[61:52]);
         wr(3'h3, r[41:32]);
         wr(3'h4, r[31:22]);
         wr(3'h2, r[51:42]);
         chk(11'h001, 11'(tp), "pending");
         run = 1'b1;
         repeat (3) @(posedge sys_clk);
         meas(r[51:42], n1, n2);
         chk(r[21:11], n1, "out one");
         chk(r[10:0], n2, "out two");
         if (i < 4) run = 1'b0;
      end
      // Restage while running: takes effect at the next boundary
      wr(3'h0, 11'h000);
      wr(3'h2, 11'h010);
      chk(11'h001, 11'(tp), "pending");
      k = 0;
      while (tp !== 1'b0 && k < 40) begin
         @(posedge sys_clk) #1 k = k + 1;
      end
      chk(11'h000, 11'(tp), "pending clear");
      if (tp !== 1'b0) summarize;
      repeat (2) @(posedge sys_clk);
      meas(11'h010, n1, n2);
      chk(11'h005, n1, "new dead");
      chk(11'h005, n2, "new dead two");
      // Late write after arming lands one period later
      run = 1'b0;
      wr(3'h1, 11'h003);
      wr(3'h2, 11'h010);
      wr(3'h1, 11'h002);
      run = 1'b1;
      @(posedge sys_clk);
      meas(11'h010, n1, n2);
      chk(11'h003, n1, "armed width");
      meas(11'h010, n1, n2);
      chk(11'h002, n1, "late width");
      chk(11'h000, 11'(tp), "pending drained");
      run = 1'b0;
      wr(3'h2, 11'h400);
      rd(3'h2, 1'b1, 8'h00);
      rd(3'h2, 1'b0, 8'h00);
      rd(3'h4, 1'b0, 8'h08);
      rep = 1'b1;
      run = 1'b1;
      k = 0;
      for (i = 0; i < 1100; i = i + 1) begin
         @(posedge sys_clk) #1 k = k + cf;
      end
      chk(11'h400, k[10:0], "one-time run");
      // Reserved mode code keeps both pins low while counting
      run = 1'b0;
      mode = 2'h1;
      @(posedge sys_clk) #1 run = 1'b1;
      meas(11'h040, n1, n2);
      chk(11'h000, n1, "off mode one");
      chk(11'h000, n2, "off mode two");
      chk(11'h001, 11'(cf), "off mode count");
      summarize;
   end
endmodule
bind dpgdt_core dpgdt_core_sva u_sva (.sys_clk(sys_clk), .rst(rst),
   .waveform_mode_select(waveform_mode_select), .repeat_select(repeat_select),
   .run_control(run_control), .data_wr_stb(data_wr_stb), .data_wr_sel(data_wr_sel),
   .data_wr_hi(data_wr_hi), .data_rd_hi(data_rd_hi), .data_rd_byte(data_rd_byte),
   .pulse_output_one(pulse_output_one), .pulse_output_two(pulse_output_two),
   .counting_flag(counting_flag), .transfer_pending(transfer_pending));
